// File: logic/sotp_pkg.sv
// shared constants and types for the security-register flash link
package sotp_pkg;
    localparam int SR_COUNT = 3;
    localparam int SR_BYTES = 256;
    localparam int MEM_WORDS = SR_COUNT * SR_BYTES;
    localparam logic [9:0] MEM_LAST = 10'h2FF;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_ERASE = 8'h44;
    localparam logic [7:0] OP_PROG = 8'h42;
    localparam logic [7:0] OP_READ = 8'h48;
    localparam logic [7:0] ADDR_HI_ZERO = 8'h00;
    localparam logic [3:0] ADDR_MID_ZERO = 4'h0;
    localparam logic [3:0] SEL_FIRST = 4'h1;
    localparam logic [3:0] SEL_LAST = 4'h3;
    localparam logic [7:0] OFFSET_FIRST = 8'h00;
    localparam logic [7:0] OFFSET_LAST = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    // frame position: byte numbers and bit numbers
    localparam logic [2:0] BYTE_OP = 3'h0;
    localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
    localparam logic [2:0] BYTE_READ_DATA = 3'h5;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_MID = 3'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // header lengths in bytes seen by the host
    localparam logic [2:0] HDR_SHORT = 3'h1;
    localparam logic [2:0] HDR_ADDR = 3'h4;
    localparam logic [2:0] HDR_READ = 3'h5;
    // timing
    localparam int CLOCK_MHZ = 25;
    localparam int ERASE_DURATION_US = 50000;
    localparam int ERASE_CYCLES = ERASE_DURATION_US * CLOCK_MHZ;
    localparam logic [1:0] SCK_RISE_PH = 2'h1;
    localparam logic [1:0] SCK_FALL_PH = 2'h3;
    localparam logic [2:0] CS_GAP_CYCLES = 3'h4;

    typedef struct packed {
        logic [7:0] hi;
        logic [3:0] sel;
        logic [3:0] mid;
        logic [7:0] offset;
    } sotp_addr_t;

    typedef struct packed {
        logic [5:0] rsvd;
        logic wr_latch;
        logic busy;
    } sotp_status_t;
endpackage

// File: logic/sotp_if.sv
// serial link between the flash controller and the security-register device
`timescale 1ns/100ps
interface sotp_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    modport dev (input sck, input cs_n, input si, output so, output so_oe);
    modport host (output sck, output cs_n, output si, input so, input so_oe);
endinterface

// File: logic/sotp_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module sotp_sync #(
    parameter int W = 1
) (
    // clock of the receiving domain
    input wire logic clk,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d;
        q_reg <= meta_reg;
    end

    assign q = q_reg;
endmodule

// File: logic/sotp_dev.sv
// security-register flash device: serial command decode, OTP store, erase timer
`timescale 1ns/100ps
// Operation
// - three 256-byte registers, individually erasable, programmable
// - erase needs write enable latch set
// - erase frame: opcode 44h plus address
// - address selects register one to three
// - erase runs only if select rises after bit 32
// - erase self-timed, busy high meanwhile
// - status read answered during erase
// - erase completion clears write enable latch
// - locked register ignores erase
// - locked register ignores program
// - program one to 256 bytes
// - program needs write enable latch set
// - program frame: 42h, address, data bytes
// - select stays low across program data
// - read frame: 48h, address, eight dummies
// - command bits sampled on rising clock
// - read data on falling edge, MSB first
// - read offset wraps FFh to 00h
// - read streams until select rises
// - read ignored while busy
module sotp_dev #(
    parameter int ERASE_CYCLES = sotp_pkg::ERASE_CYCLES
) (
    // system clock and reset
    input wire logic clock,
    input wire logic reset,
    // lock straps, one per register
    input wire logic [sotp_pkg::SR_COUNT-1:0] otp_lock_bits,
    // status
    output logic busy,
    output logic write_enable_latch,
    // serial link
    sotp_if.dev link
);
    import sotp_pkg::*;

    localparam int TW = $clog2(ERASE_CYCLES + 1);

    // link domain, rising edge
    logic [2:0] bidx_reg;
    logic [2:0] byte_no_reg;
    logic [7:0] shreg_reg;
    logic [7:0] op_reg;
    logic [15:0] addr_reg;
    logic [1:0] sel_reg;
    logic [7:0] ptr_reg;
    logic [7:0] wr_ptr_reg;
    logic [7:0] wr_data_reg;
    logic rd_ok_reg;
    logic prog_ok_reg;
    logic erase_arm_reg;
    logic wen_arm_reg;
    logic prog_any_reg;
    logic wr_tog_reg;
    logic rd_tog_reg;
    // link domain, falling edge
    logic [7:0] out_reg;
    logic oe_reg;
    // system domain
    logic busy_reg;
    logic wr_latch_reg;
    logic clr_act_reg;
    logic [9:0] clr_ptr_reg;
    logic [9:0] clr_end_reg;
    logic [TW-1:0] timer_reg;
    logic cs_d_reg;
    logic wr_d_reg;
    logic rd_d_reg;
    logic [7:0] rd_byte_reg;
    logic [7:0] mem [0:MEM_WORDS-1];

    logic [7:0] nxt;
    logic byte_end;
    sotp_addr_t fa;
    logic addr_ok;
    logic [1:0] wl_s;
    logic [5:0] cx_s;
    logic [SR_COUNT-1:0] lock_s;
    logic cs_rise;
    logic wr_evt;
    logic rd_evt;
    sotp_status_t status;

    // status levels into the link domain
    sotp_sync #(.W(2)) sync_link (
        .clk(link.sck),
        .d({wr_latch_reg, busy_reg}),
        .q(wl_s)
    );

    // frame markers and toggles into the system domain
    sotp_sync #(.W(6)) sync_sys (
        .clk(clock),
        .d({link.cs_n, erase_arm_reg, wen_arm_reg, prog_any_reg, wr_tog_reg, rd_tog_reg}),
        .q(cx_s)
    );

    sotp_sync #(.W(SR_COUNT)) sync_lock (
        .clk(clock),
        .d(otp_lock_bits),
        .q(lock_s)
    );

    assign nxt = {shreg_reg[6:0], link.si};
    assign byte_end = (bidx_reg == BIT_LAST);
    assign fa = {addr_reg, nxt};
    assign addr_ok = (fa.hi == ADDR_HI_ZERO) && (fa.mid == ADDR_MID_ZERO)
        && (fa.sel >= SEL_FIRST) && (fa.sel <= SEL_LAST);

    // bit and byte position inside a frame; select high clears it
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            bidx_reg <= BIT_FIRST;
            byte_no_reg <= BYTE_OP;
            shreg_reg <= IDLE_BYTE;
        end else begin
            shreg_reg <= nxt;
            bidx_reg <= bidx_reg + 3'h1;
            if (byte_end && byte_no_reg != BYTE_READ_DATA) begin
                byte_no_reg <= byte_no_reg + 3'h1;
            end
        end
    end

    // command decode; arm flags last one edge so any extra bit cancels them
    always_ff @(posedge link.sck or posedge reset) begin
        if (reset) begin
            op_reg <= IDLE_BYTE;
            addr_reg <= '0;
            sel_reg <= '0;
            ptr_reg <= OFFSET_FIRST;
            wr_ptr_reg <= OFFSET_FIRST;
            wr_data_reg <= IDLE_BYTE;
            rd_ok_reg <= 1'b0;
            prog_ok_reg <= 1'b0;
            erase_arm_reg <= 1'b0;
            wen_arm_reg <= 1'b0;
            prog_any_reg <= 1'b0;
            wr_tog_reg <= 1'b0;
            rd_tog_reg <= 1'b0;
        end else begin
            erase_arm_reg <= 1'b0;
            wen_arm_reg <= 1'b0;
            if (byte_no_reg == BYTE_OP && bidx_reg == BIT_FIRST) begin
                prog_any_reg <= 1'b0;
            end
            if (byte_end) begin
                case (byte_no_reg)
                    BYTE_OP: begin
                        op_reg <= nxt;
                        wen_arm_reg <= (nxt == OP_WREN);
                    end
                    BYTE_ADDR_LAST: begin
                        sel_reg <= 2'(fa.sel - SEL_FIRST);
                        ptr_reg <= fa.offset;
                        erase_arm_reg <= (op_reg == OP_ERASE) && addr_ok;
                        prog_ok_reg <= (op_reg == OP_PROG) && addr_ok
                            && wl_s[1] && !wl_s[0];
                        rd_ok_reg <= (op_reg == OP_READ) && addr_ok && !wl_s[0];
                        if (op_reg == OP_READ) begin
                            rd_tog_reg <= ~rd_tog_reg;
                        end
                    end
                    default: begin
                        if (byte_no_reg < BYTE_ADDR_LAST) begin
                            addr_reg <= {addr_reg[7:0], nxt};
                        end else if (prog_ok_reg) begin
                            // each data byte goes out while select stays low
                            wr_data_reg <= nxt;
                            wr_ptr_reg <= ptr_reg;
                            ptr_reg <= ptr_reg + 8'h01;
                            wr_tog_reg <= ~wr_tog_reg;
                            prog_any_reg <= 1'b1;
                        end
                    end
                endcase
            end
            // prefetch the next read byte mid-way through the current one
            if (rd_ok_reg && op_reg == OP_READ && byte_no_reg == BYTE_READ_DATA
                    && bidx_reg == BIT_MID) begin
                ptr_reg <= ptr_reg + 8'h01;
                rd_tog_reg <= ~rd_tog_reg;
            end
        end
    end

    always_comb begin
        status = '0;
        status.wr_latch = wl_s[1];
        status.busy = wl_s[0];
    end

    // serial output, changes on the falling clock edge
    always_ff @(negedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            out_reg <= IDLE_BYTE;
            oe_reg <= 1'b0;
        end else if (bidx_reg == BIT_FIRST && byte_no_reg != BYTE_OP) begin
            if (op_reg == OP_RDSR) begin
                out_reg <= status;
                oe_reg <= 1'b1;
            end else if (op_reg == OP_READ && rd_ok_reg && byte_no_reg == BYTE_READ_DATA) begin
                out_reg <= rd_byte_reg;
                oe_reg <= 1'b1;
            end else begin
                oe_reg <= 1'b0;
            end
        end else begin
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    assign link.so = out_reg[7];
    assign link.so_oe = oe_reg;

    assign cs_rise = cx_s[5] && !cs_d_reg;
    assign wr_evt = cx_s[1] ^ wr_d_reg;
    assign rd_evt = cx_s[0] ^ rd_d_reg;

    // busy, latch and erase sequencing; reset fills the store with erased bytes
    always_ff @(posedge clock) begin
        cs_d_reg <= cx_s[5];
        wr_d_reg <= cx_s[1];
        rd_d_reg <= cx_s[0];
        if (reset) begin
            cs_d_reg <= 1'b1;
            wr_d_reg <= 1'b0;
            rd_d_reg <= 1'b0;
            busy_reg <= 1'b1;
            wr_latch_reg <= 1'b0;
            clr_act_reg <= 1'b1;
            clr_ptr_reg <= '0;
            clr_end_reg <= MEM_LAST;
            timer_reg <= '0;
        end else begin
            if (clr_act_reg) begin
                clr_ptr_reg <= clr_ptr_reg + 10'h001;
                if (clr_ptr_reg == clr_end_reg) begin
                    clr_act_reg <= 1'b0;
                end
            end
            if (timer_reg != '0) begin
                timer_reg <= timer_reg - TW'(1);
            end
            if (busy_reg && !clr_act_reg && timer_reg == '0) begin
                busy_reg <= 1'b0;
                wr_latch_reg <= 1'b0;
            end
            if (!busy_reg && cs_rise) begin
                if (cx_s[4] && wr_latch_reg && !lock_s[sel_reg]) begin
                    busy_reg <= 1'b1;
                    timer_reg <= TW'(ERASE_CYCLES);
                    clr_ptr_reg <= {sel_reg, OFFSET_FIRST};
                    clr_end_reg <= {sel_reg, OFFSET_LAST};
                    clr_act_reg <= 1'b1;
                end else if (cx_s[3]) begin
                    wr_latch_reg <= 1'b1;
                end else if (cx_s[2]) begin
                    wr_latch_reg <= 1'b0;
                end
            end
        end
    end

    // store: erase sweep, program (bits only go 1 to 0), read fetch
    always_ff @(posedge clock) begin
        if (clr_act_reg) begin
            mem[clr_ptr_reg] <= ERASED_BYTE;
        end else if (wr_evt && !lock_s[sel_reg]) begin
            mem[{sel_reg, wr_ptr_reg}] <= mem[{sel_reg, wr_ptr_reg}] & wr_data_reg;
        end
        if (rd_evt) begin
            rd_byte_reg <= mem[{sel_reg, ptr_reg}];
        end
    end

    assign busy = busy_reg;
    assign write_enable_latch = wr_latch_reg;
endmodule

// File: logic/sotp_host.sv
// flash controller end: frames commands on the serial link, clock divided down
`timescale 1ns/100ps
module sotp_host (
    // system clock and reset
    input wire logic clock,
    input wire logic reset,
    // command
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic [8:0] cmd_count,
    output logic cmd_ready,
    output logic cmd_done,
    // program data
    input wire logic [7:0] wr_data,
    output logic wr_take,
    // read data
    output logic [7:0] rd_data,
    output logic rd_valid,
    // serial link
    sotp_if.host link
);
    import sotp_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_XFER, H_HOLD, H_GAP} sotp_hstate_t;

    sotp_hstate_t state_reg;
    logic [1:0] ph_reg;
    logic [2:0] bit_reg;
    logic [2:0] gap_reg;
    logic [2:0] hdr_reg;
    logic [9:0] byte_reg;
    logic [9:0] last_reg;
    logic [7:0] op_reg;
    logic [23:0] addr_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic sck_reg;
    logic cs_n_reg;
    logic si_reg;
    logic ready_reg;
    logic done_reg;
    logic take_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic so_s;
    logic [2:0] hdr_new;
    logic [9:0] nb;
    logic [7:0] nval;
    sotp_addr_t a;

    sotp_sync #(.W(1)) sync_so (
        .clk(clock),
        .d(link.so),
        .q(so_s)
    );

    always_comb begin
        case (cmd_op)
            OP_ERASE, OP_PROG: hdr_new = HDR_ADDR;
            OP_READ: hdr_new = HDR_READ;
            default: hdr_new = HDR_SHORT;
        endcase
    end

    // value of the byte that follows the current one
    always_comb begin
        nb = byte_reg + 10'h001;
        a = addr_reg;
        nval = IDLE_BYTE;
        if (nb == 10'(BYTE_OP + 3'h1)) begin
            nval = a.hi;
        end else if (nb == 10'(BYTE_OP + 3'h2)) begin
            nval = {a.sel, a.mid};
        end else if (nb == 10'(BYTE_ADDR_LAST)) begin
            nval = a.offset;
        end else if (op_reg == OP_PROG) begin
            nval = wr_data;
        end
    end

    always_ff @(posedge clock) begin
        take_reg <= 1'b0;
        rd_valid_reg <= 1'b0;
        done_reg <= 1'b0;
        if (reset) begin
            state_reg <= H_IDLE;
            ph_reg <= '0;
            bit_reg <= BIT_FIRST;
            gap_reg <= '0;
            hdr_reg <= HDR_SHORT;
            byte_reg <= '0;
            last_reg <= '0;
            op_reg <= IDLE_BYTE;
            addr_reg <= '0;
            tx_reg <= IDLE_BYTE;
            rx_reg <= IDLE_BYTE;
            sck_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            si_reg <= 1'b0;
            ready_reg <= 1'b0;
            rd_data_reg <= IDLE_BYTE;
        end else begin
            case (state_reg)
                H_IDLE: begin
                    ready_reg <= 1'b1;
                    if (cmd_valid && ready_reg) begin
                        ready_reg <= 1'b0;
                        state_reg <= H_XFER;
                        cs_n_reg <= 1'b0;
                        op_reg <= cmd_op;
                        addr_reg <= cmd_addr;
                        hdr_reg <= hdr_new;
                        if (cmd_op == OP_PROG || cmd_op == OP_READ || cmd_op == OP_RDSR) begin
                            last_reg <= 10'(hdr_new) + 10'(cmd_count) - 10'h001;
                        end else begin
                            last_reg <= 10'(hdr_new) - 10'h001;
                        end
                        byte_reg <= '0;
                        bit_reg <= BIT_FIRST;
                        ph_reg <= '0;
                        si_reg <= cmd_op[7];
                        tx_reg <= {cmd_op[6:0], 1'b0};
                    end
                end
                H_XFER: begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == SCK_RISE_PH) begin
                        sck_reg <= 1'b1;
                    end
                    if (ph_reg == SCK_FALL_PH) begin
                        sck_reg <= 1'b0;
                        rx_reg <= {rx_reg[6:0], so_s};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == BIT_LAST) begin
                            if (byte_reg >= 10'(hdr_reg)
                                    && (op_reg == OP_READ || op_reg == OP_RDSR)) begin
                                rd_data_reg <= {rx_reg[6:0], so_s};
                                rd_valid_reg <= 1'b1;
                            end
                            if (byte_reg == last_reg) begin
                                state_reg <= H_HOLD;
                            end else begin
                                byte_reg <= nb;
                                si_reg <= nval[7];
                                tx_reg <= {nval[6:0], 1'b0};
                                take_reg <= (op_reg == OP_PROG) && (nb >= 10'(hdr_reg));
                            end
                        end else begin
                            si_reg <= tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                H_HOLD: begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == SCK_RISE_PH) begin
                        cs_n_reg <= 1'b1;
                        gap_reg <= '0;
                        state_reg <= H_GAP;
                    end
                end
                H_GAP: begin
                    gap_reg <= gap_reg + 3'h1;
                    if (gap_reg == CS_GAP_CYCLES) begin
                        done_reg <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    assign link.sck = sck_reg;
    assign link.cs_n = cs_n_reg;
    assign link.si = si_reg;
    assign cmd_ready = ready_reg;
    assign cmd_done = done_reg;
    assign wr_take = take_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
endmodule

// File: testbench/sotp_link_asserts.sv
// link-level assertions for the security-register serial interface
`timescale 1ns/100ps
module sotp_link_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [5:0] bit_cnt;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // counts serial clock rises inside one frame
    always_ff @(posedge clock) begin
        if (reset || cs_n) begin
            bit_cnt <= 6'h00;
        end else if ($rose(sck)) begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    chk_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock high outside a frame");
    chk_frame_whole_bytes: assert property ($rose(cs_n) |-> bit_cnt[2:0] == 3'h0)
        else $error("select raised inside a byte");
    chk_sck_high_two: assert property ($rose(sck) |=> sck ##1 !sck)
        else $error("serial clock high phase wrong");
    chk_si_on_low: assert property ((!cs_n && $changed(si)) |-> !sck)
        else $error("serial input moved while clock high");
    chk_so_while_low: assert property ((so_oe && $past(so_oe) && $changed(so)) |-> !sck)
        else $error("serial output moved while clock high");
    chk_oe_in_frame: assert property (($past(cs_n) && cs_n) |-> !so_oe)
        else $error("serial output driven outside a frame");
    chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select high gap too short");
    chk_frame_start: assert property ($fell(cs_n) |-> !sck ##1 !sck)
        else $error("clock rose too early in frame");

    cover property ($rose(so_oe));
    cover property ($rose(cs_n) && bit_cnt == 6'h20);
    cover property ($rose(cs_n) && bit_cnt == 6'h08);
endmodule

// File: testbench/spi_flash_security_otp_regs_tb.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/100ps
module spi_flash_security_otp_regs_tb;
    import sotp_pkg::*;
    localparam int ERASE_LEN = 600;
    logic clock, reset, cmd_valid, cmd_ready, cmd_done, wr_take, rd_valid;
    logic busy, write_enable_latch, skip_rd, oe_seen;
    logic [7:0] cmd_op, wr_data, rd_data;
    logic [23:0] cmd_addr;
    logic [8:0] cmd_count;
    logic [2:0] otp_lock_bits;
    logic [7:0] wbuf [0:3];
    logic [7:0] exp_q [$];
    logic [23:0] bad_addr [0:3];
    int widx, fail_count, checked, cyc;

    sotp_if link_if ();
    sotp_dev #(.ERASE_CYCLES(ERASE_LEN)) u_sotp_dev (
        .clock(clock), .reset(reset), .otp_lock_bits(otp_lock_bits), .busy(busy),
        .write_enable_latch(write_enable_latch), .link(link_if));
    sotp_host u_sotp_host (
        .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
        .rd_valid(rd_valid), .link(link_if));
    sotp_link_asserts u_sotp_link_asserts (
        .clock(clock), .reset(reset), .sck(link_if.sck), .cs_n(link_if.cs_n),
        .si(link_if.si), .so(link_if.so), .so_oe(link_if.so_oe));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input logic [8:0] cnt);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = addr;
        cmd_count = cnt;
        @(posedge clock);
        while (cmd_ready !== 1'b1) @(posedge clock);
        @(negedge clock);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1) @(posedge clock);
    endtask

    task automatic wren();
        cmd(OP_WREN, 24'h000000, 9'h000);
        repeat (4) @(negedge clock);
    endtask

    task automatic prog(input logic [23:0] addr, input logic [8:0] cnt);
        widx = 0;
        wr_data = wbuf[0];
        cmd(OP_PROG, addr, cnt);
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge clock);
            n++;
        end
    endtask

    // next program byte is presented once the host has latched the current one
    always @(negedge clock) begin
        if (wr_take === 1'b1) begin
            widx++;
            wr_data = wbuf[widx[1:0]];
        end
    end

    // result watcher: every read byte seen while skip_rd is low is matched with the oldest expectation,
    // looked at mid-cycle where the host outputs have settled
    always @(negedge clock) begin
        cyc++;
        if (link_if.so_oe === 1'b1) begin
            oe_seen = 1'b1;
        end
        if (rd_valid === 1'b1 && !skip_rd) begin
            if (exp_q.size() == 0) begin
                check(rd_data, ~rd_data);
            end else begin
                check(rd_data, exp_q.pop_front());
            end
        end
        if (cyc > 12000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        int n;
        int t0;
        void'($urandom(32'h44DD196D));
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_addr = 24'h000000;
        cmd_count = 9'h000;
        wr_data = 8'h00;
        otp_lock_bits = 3'h0;
        {fail_count, checked, cyc, widx} = '0;
        {skip_rd, oe_seen} = 2'h0;
        foreach (wbuf[i]) wbuf[i] = 8'($urandom);
        bad_addr = '{24'h003000, 24'h004000, 24'h011000, 24'h001100};
        repeat (4) @(negedge clock);
        reset = 1'b0;
        wait_idle(n);
        // without the latch the byte stays erased
        prog(24'h001001, 9'h001);
        wren();
        check({7'h00, write_enable_latch}, 8'h01);
        prog(24'h0010FF, 9'h002);
        repeat (4) @(negedge clock);
        check({7'h00, write_enable_latch}, 8'h00);
        exp_q = '{8'hFF, wbuf[0], wbuf[1], 8'hFF};
        cmd(OP_READ, 24'h0010FE, 9'h004);
        @(negedge clock);
        otp_lock_bits = 3'h4;
        repeat (4) @(negedge clock);
        wren();
        prog(24'h003000, 9'h001);
        exp_q.push_back(8'hFF);
        cmd(OP_READ, 24'h003000, 9'h001);
        // locked or badly addressed erases must not start
        foreach (bad_addr[i]) begin
            wren();
            cmd(OP_ERASE, bad_addr[i], 9'h000);
            repeat (8) @(negedge clock);
            check({7'h00, busy}, 8'h00);
        end
        wren();
        cmd(OP_ERASE, 24'h00107F, 9'h000);
        t0 = cyc;
        repeat (8) @(negedge clock);
        check({7'h00, busy}, 8'h01);
        oe_seen = 1'b0;
        skip_rd = 1'b1;
        cmd(OP_READ, 24'h001000, 9'h001);
        skip_rd = 1'b0;
        check({7'h00, oe_seen}, 8'h00);
        exp_q.push_back(8'h03);
        cmd(OP_RDSR, 24'h000000, 9'h001);
        wait_idle(n);
        n = cyc - t0;
        check({7'h00, n >= ERASE_LEN - 8 && n <= ERASE_LEN + 8}, 8'h01);
        repeat (4) @(negedge clock);
        check({7'h00, write_enable_latch}, 8'h00);
        exp_q = '{8'hFF, 8'hFF};
        cmd(OP_READ, 24'h0010FF, 9'h002);
        repeat (8) @(negedge clock);
        check(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule
